// File: design/gpp_port.sv
// GPIO port: APB register file, pin blocks and shared interrupt
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module gpp_port #(
    parameter int unsigned N_PINS = gpp_pkg::PIN_MAX
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_reset,
    input  wire logic [gpp_pkg::ADDR_W-1:0] i_paddr,
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [gpp_pkg::DATA_W-1:0] i_pwdata,
    input  wire logic [3:0]                i_pstrb,
    output logic      [gpp_pkg::DATA_W-1:0] o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    input  wire logic [N_PINS-1:0]         i_pin,
    output logic      [N_PINS-1:0]         o_pin_out,
    output logic      [N_PINS-1:0]         o_pin_oe,
    output logic      [N_PINS-1:0]         o_pin_pull_up,
    output logic      [N_PINS-1:0]         o_pin_pull_dn,
    output logic      [N_PINS-1:0]         o_pin_slow,
    output logic      [N_PINS-1:0]         o_pin_in_en,
    input  wire logic [N_PINS-1:0]         i_glb_out,
    output logic      [N_PINS-1:0]         o_glb_in,
    input  wire logic                      i_irq_line,
    output logic                           o_irq_out,
    output logic                           o_irq_oe
);
    import gpp_pkg::*;

    if (N_PINS < 1 || N_PINS > PIN_MAX) begin : g_bad_pins
        $error("gpp_port: N_PINS must be 1 to 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin and line synchronisers

    logic [N_PINS-1:0] pin_s;
    logic              line_s;

    gpp_sync #(.W(N_PINS)) u_pin_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_d     (i_pin),
        .o_q     (pin_s)
    );

    gpp_sync #(.W(1)) u_line_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_d     (i_irq_line),
        .o_q     (line_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    gpp_bus_t          state;
    gpp_bus_t          next_state;
    logic [DATA_W-1:0] prdata_r;
    logic              pslverr_r;
    logic [DATA_W-1:0] rd_word_w;
    logic [DATA_W-1:0] stat_w;
    logic [N_PINS-1:0] rd_bits_w;
    logic              setup_w;
    logic              done_w;
    logic              wr_w;
    logic              rd_data_w;
    logic              mapped_w;
    logic              hit_data_w;
    logic              hit_ie_w;
    logic              hit_gs_w;
    logic              hit_dm0_w;
    logic              hit_dm1_w;
    logic              hit_dm2_w;
    logic              hit_ic0_w;
    logic              hit_ic1_w;
    logic              hit_stat_w;

    logic [N_PINS-1:0] data_r;
    logic [N_PINS-1:0] ie_r;
    logic [N_PINS-1:0] gs_r;
    logic [N_PINS-1:0] dm0_r;
    logic [N_PINS-1:0] dm1_r;
    logic [N_PINS-1:0] dm2_r;
    logic [N_PINS-1:0] ic0_r;
    logic [N_PINS-1:0] ic1_r;
    logic [N_PINS-1:0] ref_r;
    logic [N_PINS-1:0] irq_r;
    logic [N_PINS-1:0] irq_w;
    logic [N_PINS-1:0] lvl_w;

    assign hit_data_w = (i_paddr == OFS_DATA);
    assign hit_ie_w   = (i_paddr == OFS_IE);
    assign hit_gs_w   = (i_paddr == OFS_GS);
    assign hit_dm0_w  = (i_paddr == OFS_DM0);
    assign hit_dm1_w  = (i_paddr == OFS_DM1);
    assign hit_dm2_w  = (i_paddr == OFS_DM2);
    assign hit_ic0_w  = (i_paddr == OFS_IC0);
    assign hit_ic1_w  = (i_paddr == OFS_IC1);
    assign hit_stat_w = (i_paddr == OFS_STAT);
    assign mapped_w   = hit_data_w | hit_ie_w | hit_gs_w | hit_dm0_w |
                        hit_dm1_w | hit_dm2_w | hit_ic0_w | hit_ic1_w |
                        hit_stat_w;

    assign setup_w   = i_psel & ~i_penable & (state == BUS_IDLE);
    assign done_w    = i_psel & i_penable & (state == BUS_ACK);
    // Only byte lane 0 carries data; other lanes alone write nothing
    assign wr_w      = done_w & i_pwrite & i_pstrb[0] & mapped_w;
    assign rd_data_w = done_w & ~i_pwrite & hit_data_w;

    // Data address reads the pins, never the stored bits
    assign rd_bits_w = hit_data_w ? lvl_w :
                       hit_ie_w   ? ie_r  :
                       hit_gs_w   ? gs_r  :
                       hit_dm0_w  ? dm0_r :
                       hit_dm1_w  ? dm1_r :
                       hit_dm2_w  ? dm2_r :
                       hit_ic0_w  ? ic0_r :
                       hit_ic1_w  ? ic1_r : '0;

    always_comb begin
        stat_w                = '0;
        stat_w[N_PINS-1:0]    = irq_r;
        stat_w[STAT_LINE_BIT] = line_s;
    end

    assign rd_word_w = hit_stat_w ? stat_w : DATA_W'(rd_bits_w);

    always_comb begin
        case (state)
            BUS_IDLE: next_state = setup_w ? BUS_ACK : BUS_IDLE;
            BUS_ACK:  next_state = BUS_IDLE;
            default:  next_state = BUS_IDLE;
        endcase
    end

    // One wait-free access phase; read data frozen at the setup edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state     <= BUS_IDLE;
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else begin
            state <= next_state;
            if (setup_w) begin
                prdata_r  <= (mapped_w && !i_pwrite) ? rd_word_w : '0;
                pslverr_r <= ~mapped_w;
            end
        end
    end

    assign o_prdata  = prdata_r;
    assign o_pready  = state[1];
    assign o_pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            data_r <= RST_ZERO[N_PINS-1:0];
        end else if (wr_w && hit_data_w) begin
            data_r <= i_pwdata[N_PINS-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ie_r <= RST_ZERO[N_PINS-1:0];
        end else if (wr_w && hit_ie_w) begin
            ie_r <= i_pwdata[N_PINS-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            gs_r <= RST_ZERO[N_PINS-1:0];
        end else if (wr_w && hit_gs_w) begin
            gs_r <= i_pwdata[N_PINS-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dm0_r <= RST_ZERO[N_PINS-1:0];
        end else if (wr_w && hit_dm0_w) begin
            dm0_r <= i_pwdata[N_PINS-1:0];
        end
    end

    // Start every pin in analog high-Z: no crowbar current at power-up
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dm1_r <= RST_ONES[N_PINS-1:0];
        end else if (wr_w && hit_dm1_w) begin
            dm1_r <= i_pwdata[N_PINS-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dm2_r <= RST_ONES[N_PINS-1:0];
        end else if (wr_w && hit_dm2_w) begin
            dm2_r <= i_pwdata[N_PINS-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ic0_r <= RST_ZERO[N_PINS-1:0];
        end else if (wr_w && hit_ic0_w) begin
            ic0_r <= i_pwdata[N_PINS-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ic1_r <= RST_ZERO[N_PINS-1:0];
        end else if (wr_w && hit_ic1_w) begin
            ic1_r <= i_pwdata[N_PINS-1:0];
        end
    end

    // Reference equals exactly what the reader was handed
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ref_r <= RST_ZERO[N_PINS-1:0];
        end else if (rd_data_w) begin
            ref_r <= prdata_r[N_PINS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin blocks

    for (genvar g = 0; g < N_PINS; g++) begin : g_pin
        gpp_pin_if pif ();
        gpp_dm_t   mode_w;

        assign mode_w       = gpp_dm_t'({dm2_r[g], dm1_r[g], dm0_r[g]});
        assign lvl_w[g]     = pin_s[g] & (mode_w != DM_HIZ_ANALOG);
        assign pif.data     = data_r[g];
        assign pif.ie       = ie_r[g];
        assign pif.gs       = gs_r[g];
        assign pif.mode     = mode_w;
        assign pif.imode    = gpp_ic_t'({ic1_r[g], ic0_r[g]});
        assign pif.lvl      = lvl_w[g];
        assign pif.refv     = ref_r[g];
        assign pif.glb_out  = i_glb_out[g];
        assign o_pin_out[g]     = pif.drv_out;
        assign o_pin_oe[g]      = pif.drv_oe;
        assign o_pin_pull_up[g] = pif.pull_up;
        assign o_pin_pull_dn[g] = pif.pull_dn;
        assign o_pin_slow[g]    = pif.slow;
        assign o_pin_in_en[g]   = pif.in_en;
        assign o_glb_in[g]      = pif.glb_in;
        assign irq_w[g]         = pif.irq;

        gpp_pin u_pin (
            .i_clk   (i_clk),
            .i_reset (i_reset),
            .cfg     (pif.pin)
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared open-drain interrupt

    // Never drives high; the board pull-up makes the released level
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_r     <= '0;
            o_irq_out <= 1'b0;
            o_irq_oe  <= 1'b0;
        end else begin
            irq_r     <= irq_w;
            o_irq_out <= 1'b0;
            o_irq_oe  <= |irq_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    gpp_dm_t mode0_w;
    assign mode0_w = gpp_dm_t'({dm2_r[0], dm1_r[0], dm0_r[0]});

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    a_read_live: assert property (
        (done_w && !i_pwrite && hit_data_w)
            |-> (o_prdata[N_PINS-1:0] == $past(lvl_w)))
        else $error("data read did not return sensed pins");

    a_ref_capture: assert property (
        rd_data_w |=> (ref_r == $past(o_prdata[N_PINS-1:0])))
        else $error("read level not latched as reference");

    a_change_release: assert property (
        (rd_data_w && ic0_r[0] && ic1_r[0] && $stable(lvl_w[0]))
            |=> !irq_w[0] || (lvl_w[0] != $past(lvl_w[0])))
        else $error("change interrupt not released by read");

    a_irq_gated_ie: assert property (
        (ie_r == '0) |=> !o_irq_oe)
        else $error("interrupt without its enable");

    a_ie_at_once: assert property (
        ($rose(ie_r[0]) && irq_w[0]) |=> o_irq_oe)
        else $error("enable with condition true did not assert");

    a_line_held: assert property (
        (o_irq_oe && (|irq_w)) |=> o_irq_oe ##0 (o_irq_out == 1'b0))
        else $error("shared line released while a block asserts");

    a_line_release: assert property (
        (o_irq_oe && !(|irq_w)) |=> !o_irq_oe)
        else $error("shared line held without a cause");

    a_mode4_drive: assert property (
        (mode0_w == DM_OD_HIGH && !gs_r[0])
            |=> (o_pin_oe[0] == $past(data_r[0])) && o_pin_slow[0])
        else $error("mode 4 drive wrong");

    a_mode7_drive: assert property (
        (mode0_w == DM_OD_LOW && !gs_r[0])
            |=> (o_pin_oe[0] == !$past(data_r[0])) && o_pin_slow[0]
                && (!o_pin_out[0] || !o_pin_oe[0]))
        else $error("mode 7 drive wrong");

    a_mode6_off: assert property (
        (mode0_w == DM_HIZ_ANALOG) |-> !lvl_w[0] ##1
            (!o_pin_oe[0] && !o_pin_in_en[0]))
        else $error("mode 6 not high-Z with input off");

    a_glb_output: assert property (
        (gs_r[0] && mode0_w == DM_STRONG)
            |=> (o_pin_out[0] == $past(i_glb_out[0])) && o_pin_oe[0])
        else $error("global bus not driving pin");

    a_glb_input: assert property (
        (gs_r[0] && mode0_w == DM_HIZ)
            |=> (o_glb_in[0] == $past(lvl_w[0])) && !o_pin_oe[0])
        else $error("pin not fed to global input");

    a_reset_state: assert property (
        $past(i_reset) |-> (gs_r == '0) && (&dm1_r) && (&dm2_r))
        else $error("reset values wrong");

    c_data_read: cover property (rd_data_w);
    c_irq_rise: cover property ($rose(o_irq_oe));
    c_glb_out: cover property (gs_r[0] && mode0_w == DM_STRONG);
    c_back_to_back: cover property (done_w ##2 done_w);
endmodule : gpp_port

// File: design/gpp_pkg.sv
// Constants and types shared by the GPIO port pin block
//
// Overview of operation
// - Up to eight identical pins, one bit each
// - Data write sets pin level unless bypassed
// - Data read returns sensed pin levels
// - Mode 4: slow strong high, else high-Z
// - Mode 7: slow strong low, else high-Z
// - Mode 6: high-Z, digital input switched off
// - Global connection off after reset
// - Global select bypasses data; high-Z feeds input
// - Global select, driving mode: bus drives pin
// - Interrupt on high, low or change
// - Open-drain active-low interrupt, wire-ORed
// - Interrupt from enable and pin condition only
// - Enable with condition true asserts at once
// - Interrupt holds until its condition ends
// - Change mode: data read captures new reference
// - Pin level latched at data read
// - Shared line stays low while any asserts
// - Mode bits from three registers, same position
// - Upper two mode registers reset to ones
// - Modes 0 and 3 mix strong and resistive
// - Mode 1 fast strong, mode 5 slow strong
package gpp_pkg;
    localparam int unsigned PIN_MAX       = 8;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned STAT_LINE_BIT = 8;
    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IE   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_GS   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DM0  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_DM1  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DM2  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IC0  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IC1  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h20;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONES = 8'hFF;
    typedef enum logic [2:0] {
        DM_PULL_DN    = 3'h0,
        DM_STRONG     = 3'h1,
        DM_HIZ        = 3'h2,
        DM_PULL_UP    = 3'h3,
        DM_OD_HIGH    = 3'h4,
        DM_SLOW       = 3'h5,
        DM_HIZ_ANALOG = 3'h6,
        DM_OD_LOW     = 3'h7
    } gpp_dm_t;
    typedef enum logic [1:0] {
        IC_OFF    = 2'h0,
        IC_HIGH   = 2'h1,
        IC_LOW    = 2'h2,
        IC_CHANGE = 2'h3
    } gpp_ic_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } gpp_bus_t;
endpackage : gpp_pkg

// File: design/gpp_pin_if.sv
// Signals between the port and one pin block
`timescale 1ns/1ps
interface gpp_pin_if;
    import gpp_pkg::*;
    logic    data;
    logic    ie;
    logic    gs;
    gpp_dm_t mode;
    gpp_ic_t imode;
    logic    lvl;
    logic    refv;
    logic    glb_out;
    logic    drv_out;
    logic    drv_oe;
    logic    pull_up;
    logic    pull_dn;
    logic    slow;
    logic    in_en;
    logic    glb_in;
    logic    irq;
    modport port (output data, ie, gs, mode, imode, lvl, refv, glb_out,
                  input  drv_out, drv_oe, pull_up, pull_dn, slow, in_en,
                         glb_in, irq);
    modport pin  (input  data, ie, gs, mode, imode, lvl, refv, glb_out,
                  output drv_out, drv_oe, pull_up, pull_dn, slow, in_en,
                         glb_in, irq);
endinterface : gpp_pin_if

// File: design/gpp_sync.sv
// Two-flop synchroniser for pin-side levels
`timescale 1ns/1ps
module gpp_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta <= '0;
            o_q  <= '0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule : gpp_sync

// File: design/gpp_pin.sv
// One pin block: drive decode, global bypass, interrupt condition
`timescale 1ns/1ps
module gpp_pin (
    input  wire logic i_clk,
    input  wire logic i_reset,
    gpp_pin_if.pin    cfg
);
    import gpp_pkg::*;

    logic eff_w;
    logic cond_w;
    logic next_oe;
    logic next_pu;
    logic next_pd;
    logic next_slow;

    // Bypass swaps the stored bit for the global output bus
    assign eff_w = cfg.gs ? cfg.glb_out : cfg.data;

    always_comb begin
        next_oe   = 1'b0;
        next_pu   = 1'b0;
        next_pd   = 1'b0;
        next_slow = 1'b0;
        case (cfg.mode)
            DM_PULL_DN: begin
                next_oe = eff_w;
                next_pd = ~eff_w;
            end
            DM_STRONG: begin
                next_oe = 1'b1;
            end
            DM_PULL_UP: begin
                next_oe = ~eff_w;
                next_pu = eff_w;
            end
            DM_OD_HIGH: begin
                next_oe   = eff_w;
                next_slow = 1'b1;
            end
            DM_SLOW: begin
                next_oe   = 1'b1;
                next_slow = 1'b1;
            end
            DM_OD_LOW: begin
                next_oe   = ~eff_w;
                next_slow = 1'b1;
            end
            default: begin
                next_oe = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (cfg.imode)
            IC_HIGH:   cond_w = cfg.lvl;
            IC_LOW:    cond_w = ~cfg.lvl;
            IC_CHANGE: cond_w = cfg.lvl ^ cfg.refv;
            default:   cond_w = 1'b0;
        endcase
    end

    // Level, not edge: releases as soon as the cause is gone
    assign cfg.irq = cfg.ie & cond_w;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cfg.drv_out <= 1'b0;
            cfg.drv_oe  <= 1'b0;
            cfg.pull_up <= 1'b0;
            cfg.pull_dn <= 1'b0;
            cfg.slow    <= 1'b0;
            cfg.in_en   <= 1'b0;
            cfg.glb_in  <= 1'b0;
        end else begin
            cfg.drv_out <= eff_w;
            cfg.drv_oe  <= next_oe;
            cfg.pull_up <= next_pu;
            cfg.pull_dn <= next_pd;
            cfg.slow    <= next_slow;
            cfg.in_en   <= (cfg.mode != DM_HIZ_ANALOG);
            cfg.glb_in  <= cfg.gs & (cfg.mode == DM_HIZ) & cfg.lvl;
        end
    end
endmodule : gpp_pin

// File: bench/gpp_pin_load.sv
// Board-side model: pad loads, pulls and the shared interrupt line
`timescale 1ns/1ps
module gpp_pin_load #(
    parameter int unsigned N = 8
) (
    input  wire logic         i_clk,
    input  wire logic [N-1:0] i_out,
    input  wire logic [N-1:0] i_oe,
    input  wire logic [N-1:0] i_pull_up,
    input  wire logic [N-1:0] i_pull_dn,
    input  wire logic [N-1:0] i_ext_en,
    input  wire logic [N-1:0] i_ext_val,
    input  wire logic         i_irq_oe,
    input  wire logic         i_ext_irq,
    output logic      [N-1:0] o_pin,
    output logic              o_irq_line
);
    ////////////////////////////////////////////////////////////////////////
    // Undriven pad wanders: shows the inverse of its last level
    logic [N-1:0] float_q = '0;
    always @(posedge i_clk) begin
        float_q <= ~o_pin;
    end
    // Strong driver beats the board load, board load beats a pull
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
                 | (~i_oe & ~i_ext_en & (i_pull_up | (~i_pull_dn & float_q)));
    // Shared line is pulled up; any party pulls it low
    assign o_irq_line = ~(i_irq_oe | i_ext_irq);
endmodule : gpp_pin_load

// File: bench/gpio_port_pin_block_tb_top.sv
// Self-checking bench for the GPIO port pin block
`timescale 1ns/1ps
module gpio_port_pin_block_tb_top;
    import gpp_pkg::*;
    logic i_clk = 1'b0, i_reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0]  glb_out = 8'h00;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_irq_out, o_irq_oe, irq_line, perr;
    logic [7:0] pin, o_pin_out, o_pin_oe, o_pin_pull_up, o_pin_pull_dn;
    logic [7:0] o_pin_slow, o_pin_in_en, o_glb_in, x_oe;
    int err_count = 0, n_compared = 0, cyc = 0;
    gpp_port u_gpp_port (.i_clk(i_clk), .i_reset(i_reset), .i_paddr(paddr),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pin(pin),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_pin_pull_up(o_pin_pull_up), .o_pin_pull_dn(o_pin_pull_dn),
        .o_pin_slow(o_pin_slow), .o_pin_in_en(o_pin_in_en),
        .i_glb_out(glb_out), .o_glb_in(o_glb_in), .i_irq_line(irq_line),
        .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe));
    gpp_pin_load u_gpp_pin_load (.i_clk(i_clk), .i_out(o_pin_out),
        .i_oe(o_pin_oe), .i_pull_up(o_pin_pull_up),
        .i_pull_dn(o_pin_pull_dn), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .i_irq_oe(o_irq_oe), .i_ext_irq(1'b0), .o_pin(pin),
        .o_irq_line(irq_line));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    ////////////////////////////////////////////////////////////////////////
    // Master holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        logic rdy;
        n = 0;
        rdy = 1'b0;
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        // Pready, data and error taken only at the completing edge
        while (!rdy && n < 20) begin
            @(posedge i_clk);
            n++;
            rdy = (o_pready === 1'b1);
            rdat = o_prdata;
            perr = o_pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 1, rdy);
    endtask : apb
    task automatic settle();
        repeat (4) @(posedge i_clk);
    endtask : settle
    task automatic wait_irq(input logic e);
        for (int i = 0; i < 8 && o_irq_oe !== e; i++) @(posedge i_clk);
        chk("irq_oe", e, o_irq_oe);
    endtask : wait_irq
    task automatic set_mode(input logic [2:0] m);
        apb(1, OFS_DM0, {24'h0, {8{m[0]}}});
        apb(1, OFS_DM1, {24'h0, {8{m[1]}}});
        apb(1, OFS_DM2, {24'h0, {8{m[2]}}});
        settle();
    endtask : set_mode
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(0, OFS_DM1, 0); chk("dm1", 32'hFF, rdat);
        apb(0, OFS_DM2, 0); chk("dm2", 32'hFF, rdat);
        apb(0, OFS_GS, 0); chk("gs", 0, rdat);
        chk("in_en", 0, o_pin_in_en);
        chk("glb_in", 0, o_glb_in);
        apb(0, 8'h24, 0); chk("unmapped err", 1, perr);
        pstrb <= 4'h0;
        apb(1, OFS_GS, 32'hFF);
        pstrb <= 4'hF;
        apb(0, OFS_GS, 0); chk("strobe off", 0, rdat);
        $display("test reset done");
    endtask : t_reset
    task automatic t_modes();
        apb(1, OFS_DATA, 32'h55);
        for (int m = 0; m < 8; m++) begin
            set_mode(m[2:0]);
            x_oe = (m == 1 || m == 5) ? 8'hFF : (m == 0 || m == 4) ? 8'h55
                 : (m == 3 || m == 7) ? 8'hAA : 8'h00;
            chk("oe", x_oe, o_pin_oe);
            chk("out", x_oe & 8'h55, o_pin_out & o_pin_oe);
            chk("pu", (m == 3) ? 8'h55 : 8'h00, o_pin_pull_up);
            chk("pd", (m == 0) ? 8'hAA : 8'h00, o_pin_pull_dn);
            chk("slow", (m > 3 && m != 6) ? 8'hFF : 8'h00, o_pin_slow);
            chk("in_en", (m == 6) ? 8'h00 : 8'hFF, o_pin_in_en);
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_read_glb();
        ext_en <= 8'hFF; ext_val <= 8'hA5;
        set_mode(3'd0);
        apb(1, OFS_DATA, 32'h00);
        settle();
        apb(0, OFS_DATA, 0); chk("readback", 32'hA5, rdat);
        set_mode(3'd6);
        apb(0, OFS_DATA, 0); chk("mode6 read", 0, rdat);
        apb(1, OFS_GS, 32'hFF);
        set_mode(3'd2);
        chk("glb_in", 32'hA5, o_glb_in);
        glb_out <= 8'h3C;
        set_mode(3'd1);
        chk("glb drive", 32'h3C, o_pin_out & o_pin_oe);
        apb(1, OFS_GS, 0);
        settle();
        chk("data drive", 32'h00, o_pin_out & o_pin_oe);
        $display("test readback and global done");
    endtask : t_read_glb
    task automatic t_irq();
        set_mode(3'd2);
        ext_val <= 8'h01;
        apb(1, OFS_IC0, 32'h01); apb(1, OFS_IC1, 32'h00);
        apb(1, OFS_IE, 32'h01); wait_irq(1);
        chk("irq_out", 0, o_irq_out);
        ext_val <= 8'h00; wait_irq(0);
        apb(1, OFS_IC0, 32'h00); apb(1, OFS_IC1, 32'h01); wait_irq(1);
        apb(1, OFS_IC0, 32'h01); apb(1, OFS_IC1, 32'h00); wait_irq(0);
        apb(1, OFS_IC1, 32'h01); apb(0, OFS_DATA, 0); settle();
        chk("chg idle", 0, o_irq_oe);
        ext_val <= 8'h01; wait_irq(1);
        settle();
        apb(0, OFS_DATA, 0); wait_irq(0);
        ext_val <= 8'h00; wait_irq(1);
        apb(1, OFS_IE, 0); wait_irq(0);
        apb(1, OFS_IC0, 32'h03); apb(1, OFS_IC1, 32'h00);
        ext_val <= 8'h03;
        apb(1, OFS_IE, 32'h01); wait_irq(1);
        apb(1, OFS_IE, 32'h03); apb(1, OFS_IE, 32'h02); settle();
        chk("line held", 1, o_irq_oe);
        apb(0, OFS_STAT, 0); chk("stat", 32'h002, rdat);
        ext_val <= 8'h00; wait_irq(0);
        // Line level needs two sync stages before it shows in status
        settle();
        apb(0, OFS_STAT, 0);
        chk("stat idle", 32'h100, rdat);
        $display("test interrupts done");
    endtask : t_irq
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_modes();
        t_read_glb();
        t_irq();
        report_and_stop();
    end
endmodule : gpio_port_pin_block_tb_top
